// file: logic/pio_defines.vh
`ifndef PIO_DEFINES_VH
`define PIO_DEFINES_VH

// ==========================================================================
// Register map (byte addresses on the AXI4-Lite slave)
`define PIO_ADDR_W        8
// Each bidirectional port owns a 32-byte window: port index in addr[7:5]
`define PIO_PIDX_P1       3'd0
`define PIO_PIDX_P3       3'd1
`define PIO_PIDX_P9       3'd2
// Word index inside a port window, addr[4:2]
`define PIO_REG_DATA      3'd0
`define PIO_REG_DIR       3'd1
`define PIO_REG_ODRAIN    3'd2
`define PIO_REG_ALTEN     3'd3
`define PIO_REG_PADCTL    3'd4
`define PIO_REG_THRESH    3'd5
`define PIO_REG_SET       3'd6
`define PIO_REG_CLR       3'd7
`define PIO_ADDR_P5_IN    8'h60
`define PIO_ADDR_FBMAP    8'h64

// ==========================================================================
// Implemented lines per port (16 + 15 + 6 bidirectional, 10 input only)
`define PIO_P1_MASK       16'hffff
`define PIO_P3_MASK       16'h7fff
`define PIO_P9_MASK       16'h003f
`define PIO_P5_MASK       16'h03ff
`define PIO_P1_OD_MASK    16'h0000
`define PIO_P3_OD_MASK    16'h7fff
`define PIO_P9_OD_MASK    16'h003f
`define PIO_P1_THR_MASK   2'b00
`define PIO_P3_THR_MASK   2'b11
`define PIO_P9_THR_MASK   2'b01

// ==========================================================================
// Pad control field: one nibble per port byte, drive in [1:0], edge in [3:2]
`define PIO_PAD_DRV_LSB   0
`define PIO_PAD_EDGE_LSB  2
`define PIO_DRV_STRONG    2'h0
`define PIO_DRV_MEDIUM    2'h1
`define PIO_DRV_WEAK      2'h2
`define PIO_PADCTL_RST    8'h00

// ==========================================================================
// Fieldbus pin map select
`define PIO_FB_P9_0_1     2'h0
`define PIO_FB_P9_2_3     2'h1
`define PIO_FB_NONE       2'h2
`define PIO_FBMAP_RST     2'h2

`define PIO_RESP_OKAY     2'b00
`define PIO_RESP_SLVERR   2'b10

`endif

// file: logic/pin_sync.v
`timescale 1ns/1ps

// ==========================================================================
// Two-stage synchroniser for asynchronous pin levels
module pin_sync #(
  parameter W = 64
) (
  input  wire         i_ref_clk,
  input  wire         i_sys_rst,
  input  wire [W-1:0] i_async,
  output wire [W-1:0] o_sync
);

  reg [W-1:0] meta_q;
  reg [W-1:0] sync_q;

  always @(posedge i_ref_clk) begin
    if (i_sys_rst) begin
      meta_q <= {W{1'b0}};
      sync_q <= {W{1'b0}};
    end else begin
      meta_q <= i_async;
      sync_q <= meta_q;
    end
  end

  assign o_sync = sync_q;

endmodule

// file: logic/parallel_io_ports.v
// The register offsets and the AXI4-Lite register port were left to the implementer.
`timescale 1ns/1ps
`include "pio_defines.vh"

module parallel_io_ports (
  input  wire        i_ref_clk,
  input  wire        i_sys_rst,
  // AXI4-Lite slave
  input  wire [7:0]  i_s_axi_awaddr,
  input  wire        i_s_axi_awvalid,
  output wire        o_s_axi_awready,
  input  wire [31:0] i_s_axi_wdata,
  input  wire [3:0]  i_s_axi_wstrb,
  input  wire        i_s_axi_wvalid,
  output wire        o_s_axi_wready,
  output wire [1:0]  o_s_axi_bresp,
  output wire        o_s_axi_bvalid,
  input  wire        i_s_axi_bready,
  input  wire [7:0]  i_s_axi_araddr,
  input  wire        i_s_axi_arvalid,
  output wire        o_s_axi_arready,
  output wire [31:0] o_s_axi_rdata,
  output wire [1:0]  o_s_axi_rresp,
  output wire        o_s_axi_rvalid,
  input  wire        i_s_axi_rready,
  // Port 1 (16 lines)
  input  wire [15:0] i_p1_pin,
  output wire [15:0] o_p1_pin,
  output wire [15:0] o_p1_pin_oe_n,
  input  wire [15:0] i_p1_alt_out,
  output wire [15:0] o_p1_in_sync,
  output wire [3:0]  o_p1_drive,
  output wire [3:0]  o_p1_edge,
  // Port 3 (15 lines)
  input  wire [14:0] i_p3_pin,
  output wire [14:0] o_p3_pin,
  output wire [14:0] o_p3_pin_oe_n,
  input  wire [14:0] i_p3_alt_out,
  output wire [14:0] o_p3_in_sync,
  output wire [3:0]  o_p3_drive,
  output wire [3:0]  o_p3_edge,
  output wire [1:0]  o_p3_hyst,
  // Port 9 (6 lines)
  input  wire [5:0]  i_p9_pin,
  output wire [5:0]  o_p9_pin,
  output wire [5:0]  o_p9_pin_oe_n,
  input  wire [5:0]  i_p9_alt_out,
  output wire [5:0]  o_p9_in_sync,
  output wire [3:0]  o_p9_drive,
  output wire [3:0]  o_p9_edge,
  output wire        o_p9_hyst,
  // Port 5 (10 lines, input only)
  input  wire [9:0]  i_p5_pin,
  output wire [9:0]  o_p5_in_sync,
  // Fieldbus controller lines
  input  wire        i_fb_tx,
  output wire        o_fb_rx
);

  // ========================================================================
  // Pin input synchronisation
  wire [63:0] pin_async;
  wire [63:0] pin_sync_w;

  assign pin_async = {6'h00, i_p5_pin, 10'h000, i_p9_pin, 1'b0, i_p3_pin, i_p1_pin};

  pin_sync #(
    .W (64)
  ) u_pin_sync (
    .i_ref_clk (i_ref_clk),
    .i_sys_rst (i_sys_rst),
    .i_async   (pin_async),
    .o_sync    (pin_sync_w)
  );

  assign o_p1_in_sync = pin_sync_w[15:0];
  assign o_p3_in_sync = pin_sync_w[30:16];
  assign o_p9_in_sync = pin_sync_w[37:32];
  assign o_p5_in_sync = pin_sync_w[57:48];

  // ========================================================================
  // AXI4-Lite write channel: address and data taken in either order
  reg        aw_full_q;
  reg [7:0]  aw_addr_q;
  reg        w_full_q;
  reg [31:0] w_data_q;
  reg [3:0]  w_strb_q;
  reg        bvalid_q;
  reg [1:0]  bresp_q;
  wire       wr_fire;
  wire       wr_port_hit;
  wire       wr_hit;

  assign o_s_axi_awready = !aw_full_q && !bvalid_q;
  assign o_s_axi_wready  = !w_full_q && !bvalid_q;
  assign o_s_axi_bvalid  = bvalid_q;
  assign o_s_axi_bresp   = bresp_q;
  assign wr_fire         = aw_full_q && w_full_q && !bvalid_q;
  assign wr_port_hit     = (aw_addr_q[7:5] <= `PIO_PIDX_P9);
  assign wr_hit          = wr_port_hit || (aw_addr_q[7:2] == `PIO_ADDR_P5_IN >> 2)
                           || (aw_addr_q[7:2] == `PIO_ADDR_FBMAP >> 2);

  always @(posedge i_ref_clk) begin
    if (i_sys_rst) begin
      aw_full_q <= 1'b0;
      aw_addr_q <= 8'h00;
      w_full_q  <= 1'b0;
      w_data_q  <= 32'h00000000;
      w_strb_q  <= 4'h0;
      bvalid_q  <= 1'b0;
      bresp_q   <= `PIO_RESP_OKAY;
    end else begin
      if (i_s_axi_awvalid && o_s_axi_awready) begin
        aw_full_q <= 1'b1;
        aw_addr_q <= i_s_axi_awaddr;
      end
      if (i_s_axi_wvalid && o_s_axi_wready) begin
        w_full_q <= 1'b1;
        w_data_q <= i_s_axi_wdata;
        w_strb_q <= i_s_axi_wstrb;
      end
      if (wr_fire) begin
        aw_full_q <= 1'b0;
        w_full_q  <= 1'b0;
        bvalid_q  <= 1'b1;
        bresp_q   <= wr_hit ? `PIO_RESP_OKAY : `PIO_RESP_SLVERR;
      end else if (bvalid_q && i_s_axi_bready) begin
        bvalid_q <= 1'b0;
      end
    end
  end

  // ========================================================================
  // Fieldbus pin map
  reg  [1:0]  fbmap_q;
  reg  [5:0]  p9_alt_src;
  reg         fb_rx_q;

  always @(posedge i_ref_clk) begin
    if (i_sys_rst) begin
      fbmap_q <= `PIO_FBMAP_RST;
    end else if (wr_fire && (aw_addr_q == `PIO_ADDR_FBMAP) && w_strb_q[0]) begin
      fbmap_q <= w_data_q[1:0];
    end
  end

  // Route transmit line onto chosen pin pair
  always @* begin
    p9_alt_src = i_p9_alt_out;
    case (fbmap_q)
      `PIO_FB_P9_0_1: p9_alt_src[1] = i_fb_tx;
      `PIO_FB_P9_2_3: p9_alt_src[3] = i_fb_tx;
      default:        p9_alt_src    = i_p9_alt_out;
    endcase
  end

  // Unmapped receive reads recessive high so the controller sees an idle bus
  always @(posedge i_ref_clk) begin
    if (i_sys_rst) begin
      fb_rx_q <= 1'b1;
    end else begin
      case (fbmap_q)
        `PIO_FB_P9_0_1: fb_rx_q <= pin_sync_w[32];
        `PIO_FB_P9_2_3: fb_rx_q <= pin_sync_w[34];
        default:        fb_rx_q <= 1'b1;
      endcase
    end
  end

  assign o_fb_rx = fb_rx_q;

  // ========================================================================
  // Bidirectional ports, one generate block per port
  wire [47:0] alt_src_all;
  wire [47:0] pin_out_all;
  wire [47:0] pin_oe_n_all;
  wire [47:0] rd_all;
  wire [11:0] drive_all;
  wire [11:0] edge_all;
  wire [5:0]  hyst_all;

  assign alt_src_all = {10'h000, p9_alt_src, 1'b0, i_p3_alt_out, i_p1_alt_out};

  genvar p;
  genvar b;
  generate
    for (p = 0; p < 3; p = p + 1) begin : g_port
      localparam [2:0]  PIDX = p;
      localparam [15:0] LM   = (p == 0) ? `PIO_P1_MASK :
                               (p == 1) ? `PIO_P3_MASK : `PIO_P9_MASK;
      localparam [15:0] ODM  = (p == 0) ? `PIO_P1_OD_MASK :
                               (p == 1) ? `PIO_P3_OD_MASK : `PIO_P9_OD_MASK;
      localparam [1:0]  THM  = (p == 0) ? `PIO_P1_THR_MASK :
                               (p == 1) ? `PIO_P3_THR_MASK : `PIO_P9_THR_MASK;

      reg  [15:0] out_q;
      reg  [15:0] dir_q;
      reg  [15:0] od_q;
      reg  [15:0] alt_q;
      reg  [7:0]  pad_q;
      reg  [1:0]  thr_q;
      reg  [15:0] rd_w;
      wire [15:0] wmask;
      wire [15:0] wval;
      wire [15:0] sync_in;
      wire [15:0] alt_src;
      wire [15:0] drv_val;
      wire        sel;

      assign wmask   = {{8{w_strb_q[1]}}, {8{w_strb_q[0]}}};
      assign wval    = w_data_q[15:0];
      assign sel     = wr_fire && (aw_addr_q[7:5] == PIDX);
      assign sync_in = pin_sync_w[16*p+15:16*p] & LM;
      assign alt_src = alt_src_all[16*p+15:16*p];

      always @(posedge i_ref_clk) begin
        if (i_sys_rst) begin
          out_q <= 16'h0000;
          dir_q <= 16'h0000;
          od_q  <= 16'h0000;
          alt_q <= 16'h0000;
          pad_q <= `PIO_PADCTL_RST;
          thr_q <= 2'b00;
        end else if (sel) begin
          case (aw_addr_q[4:2])
            `PIO_REG_DATA:   out_q <= ((out_q & ~wmask) | (wval & wmask)) & LM;
            `PIO_REG_DIR:    dir_q <= ((dir_q & ~wmask) | (wval & wmask)) & LM;
            `PIO_REG_ODRAIN: od_q  <= ((od_q & ~wmask) | (wval & wmask)) & ODM;
            `PIO_REG_ALTEN:  alt_q <= ((alt_q & ~wmask) | (wval & wmask)) & LM;
            `PIO_REG_PADCTL: pad_q <= w_strb_q[0] ? w_data_q[7:0] : pad_q;
            `PIO_REG_THRESH: thr_q <= w_strb_q[0] ? (w_data_q[1:0] & THM) : thr_q;
            `PIO_REG_SET:    out_q <= (out_q | (wval & wmask)) & LM;
            `PIO_REG_CLR:    out_q <= out_q & ~(wval & wmask);
            default:         out_q <= out_q;
          endcase
        end
      end

      assign drv_val = (alt_q & alt_src) | (~alt_q & out_q);
      assign pin_out_all[16*p+15:16*p] = drv_val & ~od_q;
      // Inputs and open-drain highs stay undriven
      assign pin_oe_n_all[16*p+15:16*p] = ~(dir_q & LM) | (od_q & drv_val)
                                          | {16{i_sys_rst}};

      for (b = 0; b < 2; b = b + 1) begin : g_byte
        assign drive_all[4*p+2*b+1:4*p+2*b] =
          pad_q[4*b+`PIO_PAD_DRV_LSB+1:4*b+`PIO_PAD_DRV_LSB];
        assign edge_all[4*p+2*b+1:4*p+2*b] =
          pad_q[4*b+`PIO_PAD_EDGE_LSB+1:4*b+`PIO_PAD_EDGE_LSB];
      end
      assign hyst_all[2*p+1:2*p] = thr_q;

      always @* begin
        rd_w = 16'h0000;
        case (i_s_axi_araddr[4:2])
          // Pins for inputs, latch for outputs
          `PIO_REG_DATA:   rd_w = (dir_q & out_q) | (~dir_q & sync_in);
          `PIO_REG_DIR:    rd_w = dir_q;
          `PIO_REG_ODRAIN: rd_w = od_q;
          `PIO_REG_ALTEN:  rd_w = alt_q;
          `PIO_REG_PADCTL: rd_w = {8'h00, pad_q};
          `PIO_REG_THRESH: rd_w = {14'h0000, thr_q};
          default:         rd_w = 16'h0000;
        endcase
      end
      assign rd_all[16*p+15:16*p] = rd_w;
    end
  endgenerate

  assign o_p1_pin      = pin_out_all[15:0];
  assign o_p1_pin_oe_n = pin_oe_n_all[15:0];
  assign o_p3_pin      = pin_out_all[30:16];
  assign o_p3_pin_oe_n = pin_oe_n_all[30:16];
  assign o_p9_pin      = pin_out_all[37:32];
  assign o_p9_pin_oe_n = pin_oe_n_all[37:32];
  assign o_p1_drive    = drive_all[3:0];
  assign o_p1_edge     = edge_all[3:0];
  assign o_p3_drive    = drive_all[7:4];
  assign o_p3_edge     = edge_all[7:4];
  assign o_p3_hyst     = hyst_all[3:2];
  assign o_p9_drive    = drive_all[11:8];
  assign o_p9_edge     = edge_all[11:8];
  assign o_p9_hyst     = hyst_all[4];

  // ========================================================================
  // AXI4-Lite read channel: one cycle from address to data
  reg        rvalid_q;
  reg [31:0] rdata_q;
  reg [1:0]  rresp_q;
  reg [31:0] rd_word;
  reg [1:0]  rd_resp;

  assign o_s_axi_arready = !rvalid_q;
  assign o_s_axi_rvalid  = rvalid_q;
  assign o_s_axi_rdata   = rdata_q;
  assign o_s_axi_rresp   = rresp_q;

  always @* begin
    rd_word = 32'h00000000;
    rd_resp = `PIO_RESP_OKAY;
    case (i_s_axi_araddr[7:5])
      `PIO_PIDX_P1: rd_word = {16'h0000, rd_all[15:0]};
      `PIO_PIDX_P3: rd_word = {16'h0000, rd_all[31:16]};
      `PIO_PIDX_P9: rd_word = {16'h0000, rd_all[47:32]};
      default: begin
        if (i_s_axi_araddr[7:2] == `PIO_ADDR_P5_IN >> 2) begin
          rd_word = {16'h0000, pin_sync_w[63:48] & `PIO_P5_MASK};
        end else if (i_s_axi_araddr[7:2] == `PIO_ADDR_FBMAP >> 2) begin
          rd_word = {30'h00000000, fbmap_q};
        end else begin
          rd_resp = `PIO_RESP_SLVERR;
        end
      end
    endcase
  end

  always @(posedge i_ref_clk) begin
    if (i_sys_rst) begin
      rvalid_q <= 1'b0;
      rdata_q  <= 32'h00000000;
      rresp_q  <= `PIO_RESP_OKAY;
    end else if (i_s_axi_arvalid && !rvalid_q) begin
      rvalid_q <= 1'b1;
      rdata_q  <= rd_word;
      rresp_q  <= rd_resp;
    end else if (rvalid_q && i_s_axi_rready) begin
      rvalid_q <= 1'b0;
    end
  end

endmodule

// file: verif/pio_properties.sv
`timescale 1ns/1ps

// ==========================================================================
// Bus handshake and pin state checks
module pio_properties (
  input wire        i_ref_clk,
  input wire        i_sys_rst,
  input wire        i_s_axi_awvalid,
  input wire        o_s_axi_awready,
  input wire        i_s_axi_wvalid,
  input wire        o_s_axi_wready,
  input wire [1:0]  o_s_axi_bresp,
  input wire        o_s_axi_bvalid,
  input wire        i_s_axi_bready,
  input wire        i_s_axi_arvalid,
  input wire        o_s_axi_arready,
  input wire [31:0] o_s_axi_rdata,
  input wire        o_s_axi_rvalid,
  input wire        i_s_axi_rready,
  input wire [15:0] o_p1_pin_oe_n,
  input wire [14:0] o_p3_pin_oe_n,
  input wire [5:0]  o_p9_pin_oe_n,
  input wire [9:0]  i_p5_pin,
  input wire [9:0]  o_p5_in_sync
);
  default clocking @(posedge i_ref_clk); endclocking
  default disable iff (i_sys_rst);

  chk_reset_inputs: assert property ($fell(i_sys_rst) |->
    &o_p1_pin_oe_n && &o_p3_pin_oe_n && &o_p9_pin_oe_n) else $error("pin driven after reset");
  chk_sync_delay: assert property (!$past(i_sys_rst) && !$past(i_sys_rst, 2) |->
    o_p5_in_sync == $past(i_p5_pin, 2)) else $error("input sync latency wrong");
  chk_read_answer: assert property (i_s_axi_arvalid && o_s_axi_arready |=> o_s_axi_rvalid)
    else $error("read answer late");
  chk_read_hold: assert property (o_s_axi_rvalid && !i_s_axi_rready |=>
    o_s_axi_rvalid && $stable(o_s_axi_rdata)) else $error("read data dropped");
  chk_write_hold: assert property (o_s_axi_bvalid && !i_s_axi_bready |=>
    o_s_axi_bvalid && $stable(o_s_axi_bresp)) else $error("write response dropped");
  chk_read_block: assert property (o_s_axi_rvalid |-> !o_s_axi_arready)
    else $error("read taken while busy");
  chk_write_block: assert property (o_s_axi_bvalid |-> !o_s_axi_awready && !o_s_axi_wready)
    else $error("write taken while busy");
  chk_write_answer: assert property (i_s_axi_awvalid && o_s_axi_awready && i_s_axi_wvalid
    && o_s_axi_wready |-> ##2 o_s_axi_bvalid) else $error("write answer late");

  cover property (o_s_axi_rvalid && i_s_axi_rready);
  cover property (o_s_axi_bvalid && i_s_axi_bready && o_s_axi_bresp == 2'b10);
  cover property ($fell(i_sys_rst));
endmodule

bind parallel_io_ports pio_properties chk (.i_ref_clk, .i_sys_rst, .i_s_axi_awvalid,
  .o_s_axi_awready, .i_s_axi_wvalid, .o_s_axi_wready, .o_s_axi_bresp, .o_s_axi_bvalid,
  .i_s_axi_bready, .i_s_axi_arvalid, .o_s_axi_arready, .o_s_axi_rdata, .o_s_axi_rvalid,
  .i_s_axi_rready, .o_p1_pin_oe_n, .o_p3_pin_oe_n, .o_p9_pin_oe_n, .i_p5_pin, .o_p5_in_sync);

// file: verif/pin_world.sv
`timescale 1ns/1ps

// ==========================================================================
// External circuitry on one port: optional driver plus pull-up
module pin_world #(
  parameter W = 16
) (
  input  wire [W-1:0] i_dev_val,
  input  wire [W-1:0] i_dev_oe_n,
  input  wire [W-1:0] i_ext_en,
  input  wire [W-1:0] i_ext_val,
  output wire [W-1:0] o_level
);
  // released pins
  // Released and undriven pins float to the pull-up, never to a stale value
  assign o_level = (~i_dev_oe_n & i_dev_val) | (i_dev_oe_n & i_ext_en & i_ext_val)
                 | (i_dev_oe_n & ~i_ext_en);
endmodule

// file: verif/testbench.sv
`timescale 1ns/1ps
`include "pio_defines.vh"

module testbench;
  typedef struct packed {logic [7:0] a; logic [31:0] d; logic [31:0] q; logic [1:0] r;} row_t;
  logic clk = 0, rst = 1, awv = 0, wv = 0, bre = 0, arv = 0, rre = 0, fb_tx = 0;
  logic [7:0] awa = 0, ara = 0;
  logic [31:0] wd = 0, q;
  logic [1:0] r;
  logic [15:0] alt1 = 0, e1_en = 0, e1_v = 0;
  logic [14:0] alt3 = 0, e3_en = 0, e3_v = 0;
  logic [5:0] alt9 = 0, e9_en = 0, e9_v = 0;
  logic [3:0] ws = 4'hf;
  logic [9:0] p5 = 0;
  wire awr, wr_rdy, bv, arr, rv, fb_rx;
  wire [1:0] bresp, rresp;
  wire [31:0] rdata;
  wire [15:0] p1o, p1oe, p1l, p1s;
  wire [14:0] p3o, p3oe, p3l, p3s;
  wire [5:0] p9o, p9oe, p9l, p9s;
  wire [3:0] p1d, p1e, p3d, p3e, p9d, p9e;
  wire [1:0] p3h;
  wire p9h;
  int err_total = 0, tests_run = 0, cyc = 0, i;
  row_t rows [11] = '{
    '{8'h04, 32'h1234ffff, 32'hffff, `PIO_RESP_OKAY},
    '{8'h28, 32'hffff, 32'h7fff, `PIO_RESP_OKAY},
    '{8'h08, 32'hffff, 32'h0, `PIO_RESP_OKAY},
    '{8'h34, 32'h3, 32'h3, `PIO_RESP_OKAY},
    '{8'h54, 32'h3, 32'h1, `PIO_RESP_OKAY},
    '{8'h10, 32'he2, 32'he2, `PIO_RESP_OKAY},
    '{8'h30, 32'h5a, 32'h5a, `PIO_RESP_OKAY},
    '{8'h50, 32'h9, 32'h9, `PIO_RESP_OKAY},
    '{8'h64, 32'h1, 32'h1, `PIO_RESP_OKAY},
    '{8'h18, 32'h5, 32'h0, `PIO_RESP_OKAY},
    '{8'h7c, 32'h5, 32'h0, `PIO_RESP_SLVERR}};

  always #4 clk = ~clk;

  parallel_io_ports uut (.i_ref_clk(clk), .i_sys_rst(rst), .i_s_axi_awaddr(awa),
    .i_s_axi_awvalid(awv), .o_s_axi_awready(awr), .i_s_axi_wdata(wd), .i_s_axi_wstrb(ws),
    .i_s_axi_wvalid(wv), .o_s_axi_wready(wr_rdy), .o_s_axi_bresp(bresp), .o_s_axi_bvalid(bv),
    .i_s_axi_bready(bre), .i_s_axi_araddr(ara), .i_s_axi_arvalid(arv), .o_s_axi_arready(arr),
    .o_s_axi_rdata(rdata), .o_s_axi_rresp(rresp), .o_s_axi_rvalid(rv), .i_s_axi_rready(rre),
    .i_p1_pin(p1l), .o_p1_pin(p1o), .o_p1_pin_oe_n(p1oe), .i_p1_alt_out(alt1),
    .o_p1_in_sync(p1s), .o_p1_drive(p1d), .o_p1_edge(p1e), .i_p3_pin(p3l), .o_p3_pin(p3o),
    .o_p3_pin_oe_n(p3oe), .i_p3_alt_out(alt3), .o_p3_in_sync(p3s), .o_p3_drive(p3d),
    .o_p3_edge(p3e), .o_p3_hyst(p3h), .i_p9_pin(p9l), .o_p9_pin(p9o), .o_p9_pin_oe_n(p9oe),
    .i_p9_alt_out(alt9), .o_p9_in_sync(p9s), .o_p9_drive(p9d), .o_p9_edge(p9e),
    .o_p9_hyst(p9h),
    .i_p5_pin(p5), .o_p5_in_sync(), .i_fb_tx(fb_tx), .o_fb_rx(fb_rx));
  pin_world #(.W(16)) w1 (.i_dev_val(p1o), .i_dev_oe_n(p1oe), .i_ext_en(e1_en),
    .i_ext_val(e1_v), .o_level(p1l));
  pin_world #(.W(15)) w3 (.i_dev_val(p3o), .i_dev_oe_n(p3oe), .i_ext_en(e3_en),
    .i_ext_val(e3_v), .o_level(p3l));
  pin_world #(.W(6)) w9 (.i_dev_val(p9o), .i_dev_oe_n(p9oe), .i_ext_en(e9_en),
    .i_ext_val(e9_v), .o_level(p9l));

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      err_total++;
      $display("wrong value at %0t: got %h, expected %h", $time, seen, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] rs);
    @(posedge clk);
    awa <= a; wd <= d; awv <= 1; wv <= 1; bre <= 1;
    do begin
      @(posedge clk);
      if (awr) awv <= 0;
      if (wr_rdy) wv <= 0;
    end while (!bv);
    rs = bresp;
    bre <= 0;
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] rs);
    @(posedge clk);
    ara <= a; arv <= 1; rre <= 1;
    do begin
      @(posedge clk);
      if (arr) arv <= 0;
    end while (!rv);
    d = rdata;
    rs = rresp;
    rre <= 0;
  endtask

  task automatic summarize;
    $display("errors %0d, checks %0d", err_total, tests_run);
    if (err_total == 0 && tests_run > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  // Ceiling well above the fewer than 200 cycles the sequence needs
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      err_total++;
      summarize();
    end
  end

  initial begin
    repeat (8) @(posedge clk);
    rst <= 0;
    chk(p1oe, 16'hffff);
    chk(fb_rx, 1);
    rd(8'h64, q, r); chk(q, `PIO_FBMAP_RST);
    for (i = 0; i < 11; i++) begin
      wr(rows[i].a, rows[i].d, r); chk(r, rows[i].r);
      rd(rows[i].a, q, r); chk(q, rows[i].q);
      chk(r, rows[i].r);
    end
    chk({p1d, p1e}, 8'hac);
    chk({p3h, p9h}, 3'h7);
    chk({p3d, p3e, p9d, p9e}, 16'h6612);
    wr(8'h18, 32'h28, r); wr(8'h1c, 32'h25, r);
    rd(8'h00, q, r); chk(q, 32'h8);
    chk({p1o, p1oe}, 32'h00080000);
    alt1 <= 16'h0001;
    wr(8'h0c, 32'h1, r); chk(p1o, 16'h0009);
    rd(8'h00, q, r); chk(q, 32'h8);
    chk(p1s, 16'h0009);
    e3_en <= 15'h7fff; e3_v <= 15'h1554;
    repeat (4) @(posedge clk);
    rd(8'h20, q, r); chk(q, 32'h1554);
    chk({p3oe, p3s}, {15'h7fff, 15'h1554});
    wr(8'h24, 32'h3, r); wr(8'h38, 32'h1, r);
    chk({p3oe, p3o[1:0], p3l[0]}, {15'h7ffd, 3'b000});
    rd(8'h20, q, r); chk(q, 32'h1555);
    @(posedge clk); fb_tx <= 1; e9_en <= 6'h3f; e9_v <= 6'h33;
    wr(8'h44, 32'h8, r); wr(8'h4c, 32'h8, r);
    repeat (4) @(posedge clk);
    chk({p9o[3], p9oe[3], fb_rx}, 3'b100);
    chk(p9s, 6'h3b);
    wr(8'h64, 32'h0, r);
    repeat (4) @(posedge clk);
    chk({fb_rx, p9o[3]}, 2'b10);
    p5 <= 10'h3ff;
    wr(8'h60, 32'h0, r); chk(r, `PIO_RESP_OKAY);
    repeat (4) @(posedge clk);
    rd(8'h60, q, r); chk(q, 32'h3ff);
    chk($bits(p1o) + $bits(p3o) + $bits(p9o) + $bits(p5), 47);
    ws <= 4'h1;
    wr(8'h04, 32'h0, r);
    ws <= 4'hf;
    rd(8'h04, q, r); chk(q, 32'hff00);
    @(posedge clk); rst <= 1;
    @(posedge clk); chk(p1oe, 16'hffff);
    rst <= 0;
    rd(8'h04, q, r); chk(q, 32'h0);
    summarize();
  end
endmodule
